/* hw/mbpwm_defs.vh */
// Purpose: Offsets, field positions and reset values of the match based PWM unit
// Assumes: 32-bit register port, byte addresses, one word per register
// Notes:   Definitions only
`ifndef MBPWM_DEFS_VH
`define MBPWM_DEFS_VH

// Register byte offsets
`define MBPWM_ADDR_W        8
`define MBPWM_OFS_STATUS    8'h00
`define MBPWM_OFS_CLEAR     8'h04
`define MBPWM_OFS_ENABLE    8'h08
`define MBPWM_OFS_CTRL      8'h0c
`define MBPWM_OFS_CNTMODE   8'h10
`define MBPWM_OFS_PRESCALE  8'h14
`define MBPWM_OFS_PRECOUNT  8'h18
`define MBPWM_OFS_COUNT     8'h1c
`define MBPWM_OFS_MATCHCTL  8'h20
`define MBPWM_OFS_RELEASE   8'h24
`define MBPWM_OFS_OUTCTL    8'h28
`define MBPWM_OFS_MATCH0    8'h40
`define MBPWM_OFS_MATCH6    8'h58

// Control register bits
`define MBPWM_CTRL_RUN      0
`define MBPWM_CTRL_HOLD     1
`define MBPWM_CTRL_PWM      2
`define MBPWM_CTRL_SLAVE    3
`define MBPWM_CTRL_W        4

// Count mode: bits 1:0 edge select, bit 2 capture input select
`define MBPWM_MODE_TIMER    2'h0
`define MBPWM_MODE_RISE     2'h1
`define MBPWM_MODE_FALL     2'h2
`define MBPWM_MODE_BOTH     2'h3
`define MBPWM_CNTMODE_SEL   2
`define MBPWM_CNTMODE_W     3

// Match control: three bits per match register
`define MBPWM_MCTL_INT      0
`define MBPWM_MCTL_RST      1
`define MBPWM_MCTL_STOP     2
`define MBPWM_MCTL_W        21

// Output control: bits 6:2 double-edge select, bits 14:9 output enable
`define MBPWM_OUT_DBL_LSB   0
`define MBPWM_OUT_OE_LSB    9

// Reset values
`define MBPWM_RST_CTRL      4'h0
`define MBPWM_RST_CNTMODE   3'h0
`define MBPWM_RST_WORD      32'h00000000
`define MBPWM_RST_MCTL      21'h000000
`define MBPWM_RST_BITS7     7'h00
`define MBPWM_RST_OUT6      6'h00
`define MBPWM_RST_DBL       5'h00

`endif

/* hw/mbpwm_unit.v */
// Purpose: Match based PWM unit: prescaled counter, seven match registers,
//          single- and double-edge outputs, match actions and interrupt
// Assumes: Capture inputs and pins are asynchronous; master run input comes
//          from a twin unit on the same clock
// Notes:   Match values are double buffered in PWM mode; in timer mode the
//          active compares follow the shadows one clock after a write.
//          A stop match clears the run bit but the count still takes the
//          tick on which the match lands.
//          Run output mirrors the run bit so a twin unit can follow it.
//
// What this block does
// - A 32-bit count advances once each time a 32-bit prescaler completes its division.
// - The count ticks on the system clock in timer mode or on chosen edges of a capture input.
// - Seven match registers serve up to six single-edge or three double-edge outputs, or a mix.
// - In PWM mode a match on the cycle match register restarts the count at zero and begins a new cycle.
// - A single-edge output takes one further match register that drops it within the cycle.
// - Each enabled single-edge output goes high at every cycle match unless its own match equals the cycle match; a disabled one stays low.
// - A double-edge output rises on one match and falls on another, in either order.
// - Both edges of a double-edge output may sit at any count within the cycle.
// - Period and width are whole counts, and all outputs share one repetition rate.
// - Every match may interrupt, stop the count or reset the count, each with optional interrupt.
// - In PWM mode, new match values take effect only after software releases them, in step with the cycle; timer mode writes through.
// - With modulation off the unit is a plain timer with matches and no modulated outputs.
// - Two units run in lockstep with unit zero as master and unit one following its run state.
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ps
`include "mbpwm_defs.vh"

module mbpwm_unit #(
  parameter CNT_W  = 32,
  parameter NMATCH = 7,
  parameter NCAP   = 2
) (
  input  wire                     clk_sys_i,
  input  wire                     rstn_i,
  input  wire [`MBPWM_ADDR_W-1:0] addr_i,
  input  wire [31:0]              wdata_i,
  input  wire                     wr_i,
  input  wire                     rd_i,
  output reg  [31:0]              rdata_o,
  input  wire [NCAP-1:0]          cap_i,
  input  wire                     master_run_i,
  output reg                      run_o,
  output reg  [NMATCH-1:1]        pwm_o,
  output reg                      irq_o
);

  // Software visible state
  reg [`MBPWM_CTRL_W-1:0]    ctrl;
  reg [`MBPWM_CNTMODE_W-1:0] cnt_mode;
  reg [CNT_W-1:0]            prescale;
  reg [CNT_W-1:0]            pre_cnt;
  reg [CNT_W-1:0]            count;
  reg [`MBPWM_MCTL_W-1:0]    match_ctl;
  reg [NMATCH-1:0]           release_bits;
  reg [NMATCH-1:0]           status;
  reg [NMATCH-1:0]           int_en;
  reg [NMATCH-1:2]           dbl_sel;
  reg [NMATCH-1:1]           out_en;
  reg [CNT_W-1:0]            match_sh [0:NMATCH-1];
  reg [CNT_W-1:0]            match_act[0:NMATCH-1];

  // Capture input synchroniser and edge history
  reg [NCAP-1:0] cap_s1;
  reg [NCAP-1:0] cap_s2;
  reg [NCAP-1:0] cap_s3;

  wire              pwm_on    = ctrl[`MBPWM_CTRL_PWM];
  wire              hold      = ctrl[`MBPWM_CTRL_HOLD];
  // Slave unit runs only while the master runs, so it starts one clock after the master
  wire              run       = ctrl[`MBPWM_CTRL_RUN] &
                                (~ctrl[`MBPWM_CTRL_SLAVE] | master_run_i);
  wire              wr_ctrl   = wr_i && (addr_i == `MBPWM_OFS_CTRL);
  wire              wr_clear  = wr_i && (addr_i == `MBPWM_OFS_CLEAR);
  wire              wr_rel    = wr_i && (addr_i == `MBPWM_OFS_RELEASE);
  // Edge detect compares the two later stages, never the first, which may
  // still be settling from a pin change
  wire              cap_sel   = cnt_mode[`MBPWM_CNTMODE_SEL];
  wire              cap_now   = cap_s2[cap_sel];
  wire              cap_old   = cap_s3[cap_sel];

  // Tick source: every clock in timer mode, chosen edges in counter mode
  reg src_tick;
  always @* begin
    case (cnt_mode[1:0])
      `MBPWM_MODE_TIMER: src_tick = 1'b1;
      `MBPWM_MODE_RISE:  src_tick = cap_now & ~cap_old;
      `MBPWM_MODE_FALL:  src_tick = ~cap_now & cap_old;
      default:           src_tick = cap_now ^ cap_old;
    endcase
  end

  // Count advances when the prescaler wraps
  // A prescale of zero ticks on every source event
  wire tick = run & ~hold & src_tick & (pre_cnt == prescale);

  // Match detection per register
  wire [NMATCH-1:0] hit;
  wire [NMATCH-1:0] hit_rst;
  wire [NMATCH-1:0] hit_stop;
  wire [NMATCH-1:0] hit_int;
  genvar gi;
  generate
    for (gi = 0; gi < NMATCH; gi = gi + 1) begin : g_match
      assign hit[gi]      = tick & (count == match_act[gi]);
      assign hit_int[gi]  = hit[gi] & match_ctl[3*gi+`MBPWM_MCTL_INT];
      assign hit_stop[gi] = hit[gi] & match_ctl[3*gi+`MBPWM_MCTL_STOP];
      // Cycle match always restarts the count in PWM mode
      assign hit_rst[gi]  = hit[gi] & (match_ctl[3*gi+`MBPWM_MCTL_RST] |
                                       ((gi == 0) & pwm_on));
    end
  endgenerate

  wire cycle_hit = hit[0] & pwm_on;

  // Capture synchroniser; edge logic reads only the second and third stage
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cap_s1 <= {NCAP{1'b0}};
      cap_s2 <= {NCAP{1'b0}};
      cap_s3 <= {NCAP{1'b0}};
    end else begin
      cap_s1 <= cap_i;
      cap_s2 <= cap_s1;
      cap_s3 <= cap_s2;
    end
  end

  // Prescaler and counter
  // Hold parks both counters at zero so a paired unit starts from the same state
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pre_cnt <= `MBPWM_RST_WORD;
      count   <= `MBPWM_RST_WORD;
    end else if (hold) begin
      pre_cnt <= `MBPWM_RST_WORD;
      count   <= `MBPWM_RST_WORD;
    end else if (run && src_tick) begin
      if (pre_cnt == prescale) begin
        pre_cnt <= `MBPWM_RST_WORD;
        if (|hit_rst)
          count <= `MBPWM_RST_WORD;
        else
          count <= count + 1'b1;
      end else begin
        pre_cnt <= pre_cnt + 1'b1;
      end
    end
  end

  // Control register; a stop match clears the run bit
  // A software write in the same cycle as a stop match wins
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl <= `MBPWM_RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl <= wdata_i[`MBPWM_CTRL_W-1:0];
    end else if (|hit_stop) begin
      ctrl[`MBPWM_CTRL_RUN] <= 1'b0;
    end
  end

  // Plain configuration registers
  // Only the decoded word of each write is taken; other addresses are ignored
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_mode  <= `MBPWM_RST_CNTMODE;
      prescale  <= `MBPWM_RST_WORD;
      match_ctl <= `MBPWM_RST_MCTL;
      int_en    <= `MBPWM_RST_BITS7;
      dbl_sel   <= `MBPWM_RST_DBL;
      out_en    <= `MBPWM_RST_OUT6;
    end else if (wr_i) begin
      if (addr_i == `MBPWM_OFS_CNTMODE)
        cnt_mode <= wdata_i[`MBPWM_CNTMODE_W-1:0];
      else if (addr_i == `MBPWM_OFS_PRESCALE)
        prescale <= wdata_i[CNT_W-1:0];
      else if (addr_i == `MBPWM_OFS_MATCHCTL)
        match_ctl <= wdata_i[`MBPWM_MCTL_W-1:0];
      else if (addr_i == `MBPWM_OFS_ENABLE)
        int_en <= wdata_i[NMATCH-1:0];
      else if (addr_i == `MBPWM_OFS_OUTCTL) begin
        dbl_sel <= wdata_i[`MBPWM_OUT_DBL_LSB+NMATCH-1:`MBPWM_OUT_DBL_LSB+2];
        out_en  <= wdata_i[`MBPWM_OUT_OE_LSB+NMATCH-2:`MBPWM_OUT_OE_LSB];
      end
    end
  end

  // Release bits: software sets, cycle transfer clears; a set in the same
  // cycle wins so a fresh release is never dropped
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i)
      release_bits <= `MBPWM_RST_BITS7;
    else if (wr_rel)
      release_bits <= (cycle_hit ? {NMATCH{1'b0}} : release_bits) |
                      wdata_i[NMATCH-1:0];
    else if (cycle_hit)
      release_bits <= {NMATCH{1'b0}};
  end

  // Shadow and active match values
  generate
    for (gi = 0; gi < NMATCH; gi = gi + 1) begin : g_mreg
      // Offset worked out at full width, then cut to the address width
      localparam [31:0] OFS_FULL = `MBPWM_OFS_MATCH0 + 4 * gi;
      wire [`MBPWM_ADDR_W-1:0] ofs = OFS_FULL[`MBPWM_ADDR_W-1:0];
      always @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
          match_sh[gi]  <= `MBPWM_RST_WORD;
          match_act[gi] <= `MBPWM_RST_WORD;
        end else begin
          if (wr_i && (addr_i == ofs))
            match_sh[gi] <= wdata_i[CNT_W-1:0];
          // Timer mode writes through; PWM mode waits for release and cycle
          if (!pwm_on)
            match_act[gi] <= match_sh[gi];
          else if (cycle_hit && release_bits[gi])
            match_act[gi] <= match_sh[gi];
        end
      end
    end
  endgenerate

  // Sticky match flags; hardware set wins over software clear
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i)
      status <= `MBPWM_RST_BITS7;
    else
      status <= (status & ~(wr_clear ? wdata_i[NMATCH-1:0] : {NMATCH{1'b0}}))
                | hit_int;
  end

  // Output edge logic; clear beats set when both land on one count
  // A single-edge output whose match equals the cycle match stays low,
  // which is how software asks for a constant low level
  generate
    for (gi = 1; gi < NMATCH; gi = gi + 1) begin : g_out
      wire dbl = (gi >= 2) ? dbl_sel[(gi >= 2) ? gi : 2] : 1'b0;
      wire set = dbl ? hit[gi-1] : hit[0];
      wire clr = hit[gi];
      always @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i)
          pwm_o[gi] <= 1'b0;
        else if (!pwm_on || !out_en[gi])
          pwm_o[gi] <= 1'b0;
        else if (clr)
          pwm_o[gi] <= 1'b0;
        else if (set)
          pwm_o[gi] <= 1'b1;
      end
    end
  endgenerate

  // Interrupt and run outputs
  // Interrupt lags the flag by one clock; software sees the flag first
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_o <= 1'b0;
      run_o <= 1'b0;
    end else begin
      irq_o <= |(status & int_en);
      run_o <= ctrl[`MBPWM_CTRL_RUN];
    end
  end

  // Read mux; unmapped and write-only addresses read zero
  // Match offsets read the shadow, which is what software wrote last
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i)
      rdata_o <= `MBPWM_RST_WORD;
    else if (!rd_i)
      rdata_o <= `MBPWM_RST_WORD;
    else if (addr_i == `MBPWM_OFS_STATUS)
      rdata_o <= {25'h0000000, status};
    else if (addr_i == `MBPWM_OFS_ENABLE)
      rdata_o <= {25'h0000000, int_en};
    else if (addr_i == `MBPWM_OFS_CTRL)
      rdata_o <= {28'h0000000, ctrl};
    else if (addr_i == `MBPWM_OFS_CNTMODE)
      rdata_o <= {29'h00000000, cnt_mode};
    else if (addr_i == `MBPWM_OFS_PRESCALE)
      rdata_o <= prescale;
    else if (addr_i == `MBPWM_OFS_PRECOUNT)
      rdata_o <= pre_cnt;
    else if (addr_i == `MBPWM_OFS_COUNT)
      rdata_o <= count;
    else if (addr_i == `MBPWM_OFS_MATCHCTL)
      rdata_o <= {11'h000, match_ctl};
    else if (addr_i == `MBPWM_OFS_RELEASE)
      rdata_o <= {25'h0000000, release_bits};
    else if (addr_i == `MBPWM_OFS_OUTCTL)
      rdata_o <= {17'h00000, out_en, 2'h0, dbl_sel, 2'h0};
    else if (addr_i >= `MBPWM_OFS_MATCH0 && addr_i <= `MBPWM_OFS_MATCH6 &&
             addr_i[1:0] == 2'h0)
      rdata_o <= match_sh[addr_i[4:2] - 3'h0];
    else
      rdata_o <= `MBPWM_RST_WORD;
  end

endmodule

/* verification/mbpwm_checker.sv */
// Purpose: Port-level assertions for the match based PWM unit
// Assumes: Single clock domain, async active-low reset
// Notes:   Shadows of enable, output enable and mode track bus writes
`timescale 1ns/1ps
module mbpwm_checker (
  input wire        clk_sys_i,
  input wire        rstn_i,
  input wire [7:0]  addr_i,
  input wire [31:0] wdata_i,
  input wire        wr_i,
  input wire        rd_i,
  input wire [31:0] rdata_o,
  input wire        run_o,
  input wire [6:1]  pwm_o,
  input wire        irq_o
);
  reg [6:0] ien;
  reg [5:0] oe;
  reg       pwm;

  // Shadows of what software last wrote
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ien <= 7'h00;
      oe  <= 6'h00;
      pwm <= 1'b0;
    end else if (wr_i) begin
      if (addr_i == 8'h08) ien <= wdata_i[6:0];
      if (addr_i == 8'h28) oe <= wdata_i[14:9];
      if (addr_i == 8'h0c) pwm <= wdata_i[2];
    end
  end

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data not idle");
  a_clear_reads_zero: assert property (rd_i && addr_i == 8'h04 |=> rdata_o == 32'h0)
    else $error("clear register readable");
  a_enable_readback: assert property (rd_i && addr_i == 8'h08 |=> rdata_o == {25'h0, $past(ien)})
    else $error("enable readback wrong");
  a_irq_masked: assert property (ien == 7'h0 && $past(ien) == 7'h0 |-> !irq_o)
    else $error("interrupt while masked");
  a_off_output_low: assert property ((pwm_o & ~oe & ~$past(oe)) == 6'h0)
    else $error("disabled output high");
  a_timer_no_pwm: assert property (!pwm && !$past(pwm) |-> pwm_o == 6'h0)
    else $error("output high in timer mode");
  a_run_follows: assert property (wr_i && addr_i == 8'h0c |-> ##2 run_o == $past(wdata_i[0], 2))
    else $error("run output wrong");
  a_run_rise_cause: assert property ($rose(run_o) |-> $past(wr_i, 2) && $past(addr_i, 2) == 8'h0c)
    else $error("run rose uncommanded");
endmodule

bind mbpwm_unit mbpwm_checker u_chk (.clk_sys_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i,
  .rdata_o, .run_o, .pwm_o, .irq_o);

/* verification/mbpwm_stage_model.sv */
// Purpose: Power stage input model, counts high cycles and rises of one output
// Assumes: Outputs sampled on the system clock
// Notes:   Clear restarts both counts
`timescale 1ns/1ps
module mbpwm_stage_model (
  input  wire        clk_i,
  input  wire        clr_i,
  input  wire [5:0]  pwm_i,
  input  wire [2:0]  sel_i,
  output reg  [15:0] hi_o,
  output reg  [15:0] rise_o
);
  reg prev;

  // Duty and edge counting on the selected output
  always @(posedge clk_i) begin
    prev <= pwm_i[sel_i-3'd1];
    if (clr_i) begin
      hi_o   <= 16'h0;
      rise_o <= 16'h0;
    end else begin
      hi_o   <= hi_o + {15'h0, pwm_i[sel_i-3'd1]};
      rise_o <= rise_o + {15'h0, pwm_i[sel_i-3'd1] & ~prev};
    end
  end
endmodule

/* verification/test_match_based_pwm_unit.sv */
// Purpose: Self-checking bench for the match based PWM unit
// Assumes: Prescale 0 unless a scenario sets it
// Notes:   Duty measured over whole periods by the stage model
`timescale 1ns/1ps
module test_match_based_pwm_unit;
  reg         clk_sys_i, rstn_i, wr_i, rd_i, master_run_i, clr;
  reg  [7:0]  addr_i;
  reg  [31:0] wdata_i, rv;
  reg  [1:0]  cap_i;
  reg  [2:0]  sel;
  wire [31:0] rdata_o;
  wire        run_o, irq_o;
  wire [6:1]  pwm_o;
  wire [15:0] hi, rise;
  integer     n_fail, cmp_count, cyc, i;

  mbpwm_unit uut (.clk_sys_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .cap_i,
    .master_run_i, .run_o, .pwm_o, .irq_o);
  mbpwm_stage_model stage (.clk_i(clk_sys_i), .clr_i(clr), .pwm_i(pwm_o), .sel_i(sel),
    .hi_o(hi), .rise_o(rise));

  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  // Hang guard, well above the full sequence
  always @(posedge clk_sys_i) begin
    cyc = cyc + 1;
    if (cyc == 6000) begin
      n_fail = n_fail + 1;
      finish_test;
    end
  end

  task finish_test;
    begin
      if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask

  task chk(input [127:0] nm, input [31:0] e, input [31:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("[ERR] %0s exp %h got %h", nm, e, g);
      end
    end
  endtask

  task wt(input integer n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_sys_i);
      addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
    end
  endtask

  // Read data is taken at the edge after the strobe edge
  task rd(input [7:0] a);
    begin
      @(posedge clk_sys_i);
      addr_i <= a; rd_i <= 1'b1;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      @(posedge clk_sys_i);
      rv = rdata_o;
    end
  endtask

  task meas(input [2:0] s, input integer n);
    begin
      sel <= s;
      @(posedge clk_sys_i) clr <= 1'b1;
      @(posedge clk_sys_i) clr <= 1'b0;
      wt(n);
      #1;
    end
  endtask

  task t_regs;
    begin
      rd(8'h0c); chk("ctrl", 0, rv);
      rd(8'h3c); chk("unmapped", 0, rv);
      wr(8'h08, 32'hffffffff); rd(8'h08); chk("enable", 32'h7f, rv);
      wr(8'h08, 0);
    end
  endtask

  // Period 4: single edge on out1, double edge on out2, then re-release
  task t_pwm;
    begin
      wr(8'h40, 3); wr(8'h44, 1); wr(8'h48, 2); wr(8'h28, 32'h604); wr(8'h24, 7);
      wr(8'h0c, 5); wt(8);
      meas(1, 40); chk("hi1", 20, hi); chk("rise1", 10, rise);
      meas(2, 40); chk("hi2", 10, hi); chk("rise2", 10, rise);
      wr(8'h48, 0); meas(2, 40); chk("unreleased", 10, hi);
      wr(8'h24, 4); wt(8); meas(2, 40); chk("neg2", 30, hi);
    end
  endtask

  task t_irq;
    begin
      wr(8'h20, 8); wr(8'h08, 2); wt(8); chk("irq_on", 1, irq_o);
      wr(8'h08, 0); wt(2); chk("irq_mask", 0, irq_o);
      rd(8'h00); chk("stat1", 1, rv[1]);
      wr(8'h0c, 4); wr(8'h04, 2); wr(8'h08, 2); wt(2); chk("irq_clr", 0, irq_o);
      rd(8'h04); chk("clear_rd", 0, rv);
      wr(8'h08, 0); wr(8'h20, 0);
    end
  endtask

  // Timer mode, match3 stops the count one past its value
  task t_stop;
    begin
      wr(8'h0c, 2); wr(8'h0c, 0); wr(8'h4c, 5); wr(8'h20, 32'h800); wr(8'h0c, 1); wt(20);
      chk("run_stop", 0, run_o); rd(8'h1c); chk("cnt_stop", 6, rv);
      // Stop and reset on one match: count returns to zero and stays there
      wr(8'h0c, 2); wr(8'h20, 32'hc00); wr(8'h0c, 1); wt(20);
      rd(8'h1c); chk("cnt_rst", 0, rv); chk("run_rst", 0, run_o);
      wr(8'h20, 0);
    end
  endtask

  task t_slave;
    begin
      wr(8'h14, 3); wr(8'h0c, 2); wr(8'h0c, 9); wt(20);
      rd(8'h1c); chk("slave_idle", 0, rv);
      @(posedge clk_sys_i) master_run_i <= 1'b1;
      wt(40); rd(8'h1c); chk("slave_run", 10, rv);
      master_run_i <= 1'b0; wr(8'h14, 0);
    end
  endtask

  // Pulses of four clocks high and five low on the chosen capture pins
  task pulse(input [1:0] v, input integer n);
    begin
      for (i = 0; i < n; i = i + 1) begin
        @(posedge clk_sys_i) cap_i <= v;
        wt(4);
        cap_i <= 2'h0;
        wt(4);
      end
      wt(6);
    end
  endtask

  // Rising edges of input 0, falling edges of input 1, both edges of input 0
  task t_cap;
    begin
      wr(8'h0c, 2); wr(8'h10, 1); wr(8'h0c, 1); pulse(2'h1, 5);
      rd(8'h1c); chk("cap_cnt", 5, rv);
      wr(8'h0c, 2); wr(8'h10, 6); wr(8'h0c, 1); pulse(2'h2, 3);
      rd(8'h1c); chk("cap_fall", 3, rv);
      wr(8'h0c, 2); wr(8'h10, 3); wr(8'h0c, 1); pulse(2'h1, 2);
      rd(8'h1c); chk("cap_both", 4, rv);
    end
  endtask

  initial begin
    n_fail = 0; cmp_count = 0; cyc = 0; rstn_i = 1'b0; wr_i = 1'b0; rd_i = 1'b0;
    addr_i = 8'h00; wdata_i = 32'h0; cap_i = 2'h0; master_run_i = 1'b0; clr = 1'b0;
    sel = 3'h1; rv = 32'h0;
    wt(2);
    rstn_i <= 1'b1;
    t_regs; t_pwm; t_irq; t_stop; t_slave; t_cap;
    finish_test;
  end
endmodule
